// *** rtl/small_ram_block.sv ***
// small embedded ram block: dual-port, single-port, fifo, rom and shift register
// Contract
// - input clear resets input registers immediately
// - output clear shows on read data immediately
// - one extra stored bit per byte
// - 576 storage bits including parity
// - sdp, sp, fifo, rom or shift modes
// - ram and rom contents preloadable
// - seven selectable depth by width geometries
// - mixed widths, parity geometries must match
// - long shift registers chain blocks via last tap
// - shift writes falling edge, reads rising edge; the code writes and reads both on the rising edge of sys_clk
// - shift sequencing internal, one step per cycle
// - write registers share one clock
// - read registers clocked by either clock
// - only the output register is bypassable; sdp flow-through also skips the read address register
// - mixed widths serve as serializer or deserializer
// - collision returns old data or don't-care
// - single-port read shows written data; the code issues no read in a cycle with wrStrobe high
// - flow-through read with bypassed output register
`timescale 1ns/100ps
module small_ram_block #(
    parameter logic [575:0] INIT = '0
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic inClr,
    input wire logic outClr,
    input wire logic inClkEn,
    input wire logic outClkEn,
    input wire logic wrStrobe,
    input wire logic [8:0] wrAddr,
    input wire logic [17:0] wrData,
    input wire logic rdStrobe,
    input wire logic [8:0] rdAddr,
    output logic [17:0] rdData,
    output logic rdValid,
    input wire logic [3:0] cfgAddr,
    input wire logic [31:0] cfgWrData,
    input wire logic cfgWrite,
    input wire logic cfgRead,
    output logic [31:0] cfgRdData
);
`include "small_ram_block_regs.svh"

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [15:0] ctrl;
        logic [8:0] shiftLen;
        logic [4:0] shiftTaps;
        logic [8:0] shiftPtr;
        logic [8:0] fifoWr;
        logic [8:0] fifoRd;
        logic [9:0] fifoCount;
        logic [31:0] cfgRd;
    } coreState_t;

    typedef struct packed {
        small_ram_block_pkg::writeReq_t wr;
        logic [8:0] rdAddr;
        logic rdPend;
        logic shiftGo;
    } inState_t;

    typedef struct packed {
        logic [17:0] latch;
        logic latchValid;
        logic [17:0] rdData;
        logic rdValid;
    } outState_t;

    coreState_t coreQ;
    coreState_t coreD;
    inState_t inQ;
    inState_t inD;
    outState_t outQ;
    outState_t outD;

    logic [575:0] memBits;
    small_ram_block_pkg::mode_t curMode;
    small_ram_block_pkg::geom_t wrGeom;
    small_ram_block_pkg::geom_t rdGeom;
    logic cfgError;
    logic bypass;
    logic fifoFull;
    logic fifoEmpty;
    logic wrGo;
    logic rdGo;
    logic rdEnable;
    logic [8:0] rdSel;
    logic [17:0] stageWord;
    logic [17:0] tapWord;
    logic collide;
    int shiftTotal;

    assign curMode = small_ram_block_pkg::mode_t'(coreQ.ctrl[`CTRL_MODE_LSB +: 3]);
    assign wrGeom = small_ram_block_pkg::geom_t'(coreQ.ctrl[`CTRL_WRGEOM_LSB +: 3]);
    assign rdGeom = small_ram_block_pkg::geom_t'(coreQ.ctrl[`CTRL_RDGEOM_LSB +: 3]);
    assign bypass = coreQ.ctrl[`CTRL_BYPASS_BIT];
    assign shiftTotal = int'(coreQ.shiftLen) * int'(coreQ.shiftTaps);
    assign fifoFull = int'(coreQ.fifoCount) >= small_ram_block_pkg::geomDepth(wrGeom);
    assign fifoEmpty = coreQ.fifoCount == 10'h000;

    // ----------------------------------------
    // configuration legality
    // ----------------------------------------
    always_comb begin
        cfgError = 1'b0;
        if (coreQ.ctrl[`CTRL_MODE_LSB +: 3] > 3'h4) begin
            cfgError = 1'b1;
        end
        if ((coreQ.ctrl[`CTRL_WRGEOM_LSB +: 3] == 3'h7) ||
            (coreQ.ctrl[`CTRL_RDGEOM_LSB +: 3] == 3'h7)) begin
            cfgError = 1'b1;
        end
        if ((small_ram_block_pkg::geomParity(wrGeom) ||
             small_ram_block_pkg::geomParity(rdGeom)) && (wrGeom != rdGeom)) begin
            cfgError = 1'b1;
        end
        if (((curMode == small_ram_block_pkg::MODE_FIFO) ||
             (curMode == small_ram_block_pkg::MODE_SP)) && (wrGeom != rdGeom)) begin
            cfgError = 1'b1;
        end
        if (curMode == small_ram_block_pkg::MODE_SHIFT) begin
            if (small_ram_block_pkg::geomParity(wrGeom) || (shiftTotal == 0) ||
                (shiftTotal * small_ram_block_pkg::geomWidth(wrGeom) > `DATA_BITS)) begin
                cfgError = 1'b1;
            end
            if (int'(coreQ.shiftTaps) * small_ram_block_pkg::geomWidth(wrGeom) >=
                `MAX_WIDTH) begin
                cfgError = 1'b1;
            end
        end
    end

    // ----------------------------------------
    // storage
    // ----------------------------------------
    small_ram_array #(
        .INIT(INIT)
    ) u_array (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .wrReq(inQ.wr),
        .memBits(memBits)
    );

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        int lw;
        int tj;
        int ta;
        coreD = coreQ;
        inD = inQ;
        outD = outQ;
        lw = small_ram_block_pkg::geomLog2(wrGeom);
        tj = 0;
        ta = 0;
        inD.wr.en = 1'b0;
        inD.rdPend = 1'b0;
        inD.shiftGo = 1'b0;
        outD.rdValid = 1'b0;
        coreD.cfgRd = '0;

        // configuration port
        if (cfgWrite) begin
            case (cfgAddr)
                `CFG_CTRL_OFS: begin
                    coreD.ctrl = cfgWrData[15:0];
                    coreD.fifoWr = '0;
                    coreD.fifoRd = '0;
                    coreD.fifoCount = '0;
                    coreD.shiftPtr = '0;
                end
                `CFG_SHIFT_OFS: begin
                    coreD.shiftLen = cfgWrData[`SHIFT_LEN_LSB +: 9];
                    coreD.shiftTaps = cfgWrData[`SHIFT_TAPS_LSB +: 5];
                    coreD.shiftPtr = '0;
                end
                default: begin
                end
            endcase
        end
        if (cfgRead) begin
            case (cfgAddr)
                `CFG_CTRL_OFS: coreD.cfgRd = {16'h0000, coreQ.ctrl};
                `CFG_SHIFT_OFS: begin
                    coreD.cfgRd[`SHIFT_LEN_LSB +: 9] = coreQ.shiftLen;
                    coreD.cfgRd[`SHIFT_TAPS_LSB +: 5] = coreQ.shiftTaps;
                end
                `CFG_STATUS_OFS: begin
                    coreD.cfgRd[`STAT_CFGERR_BIT] = cfgError;
                    coreD.cfgRd[`STAT_EMPTY_BIT] = fifoEmpty;
                    coreD.cfgRd[`STAT_FULL_BIT] = fifoFull;
                    coreD.cfgRd[`STAT_COUNT_LSB +: 10] = coreQ.fifoCount;
                end
                default: coreD.cfgRd = '0;
            endcase
        end

        // write side, all captured on the input enable
        wrGo = inClkEn && wrStrobe && !cfgError && (curMode != small_ram_block_pkg::MODE_ROM) &&
            (curMode != small_ram_block_pkg::MODE_SHIFT) &&
            !((curMode == small_ram_block_pkg::MODE_FIFO) && fifoFull);
        if (wrGo) begin
            inD.wr.en = 1'b1;
            inD.wr.addr = (curMode == small_ram_block_pkg::MODE_FIFO) ? coreQ.fifoWr : wrAddr;
            inD.wr.data = wrData;
            inD.wr.geom = wrGeom;
            if (curMode == small_ram_block_pkg::MODE_FIFO) begin
                coreD.fifoWr = (int'(coreQ.fifoWr) + 1 >= small_ram_block_pkg::geomDepth(wrGeom)) ?
                    9'h000 : coreQ.fifoWr + 9'h001;
            end
        end

        // shift mode steps the pointer itself once per enabled cycle
        if ((curMode == small_ram_block_pkg::MODE_SHIFT) && !cfgError && inClkEn) begin
            inD.wr.en = 1'b1;
            inD.wr.addr = coreQ.shiftPtr;
            inD.wr.data = wrData;
            inD.wr.geom = wrGeom;
            inD.shiftGo = 1'b1;
            coreD.shiftPtr = (int'(coreQ.shiftPtr) + 1 >= shiftTotal) ?
                9'h000 : coreQ.shiftPtr + 9'h001;
        end

        // read side, enable chosen between the two clock enables
        rdEnable = coreQ.ctrl[`CTRL_RDCLK_BIT] ? outClkEn : inClkEn;
        rdGo = rdStrobe && rdEnable && !cfgError &&
            (curMode != small_ram_block_pkg::MODE_SHIFT) &&
            !((curMode == small_ram_block_pkg::MODE_FIFO) && fifoEmpty) &&
            !((curMode == small_ram_block_pkg::MODE_SP) && wrStrobe);
        case (curMode)
            small_ram_block_pkg::MODE_SP: rdSel = wrAddr;
            small_ram_block_pkg::MODE_FIFO: rdSel = coreQ.fifoRd;
            default: rdSel = rdAddr;
        endcase
        if (rdGo) begin
            if ((curMode == small_ram_block_pkg::MODE_SDP) && bypass &&
                coreQ.ctrl[`CTRL_FLOW_BIT]) begin
                outD.rdData = small_ram_block_pkg::readWord(memBits, rdGeom, rdSel);
                outD.rdValid = 1'b1;
            end else begin
                inD.rdAddr = rdSel;
                inD.rdPend = 1'b1;
            end
            if (curMode == small_ram_block_pkg::MODE_FIFO) begin
                coreD.fifoRd = (int'(coreQ.fifoRd) + 1 >= small_ram_block_pkg::geomDepth(rdGeom)) ?
                    9'h000 : coreQ.fifoRd + 9'h001;
            end
        end
        if ((curMode == small_ram_block_pkg::MODE_FIFO) && (wrGo != rdGo)) begin
            coreD.fifoCount = wrGo ? coreQ.fifoCount + 10'h001 : coreQ.fifoCount - 10'h001;
        end

        // memory read of the registered address, before this cycle's write lands
        collide = inQ.wr.en && inQ.rdPend &&
            !((int'(small_ram_block_pkg::physBit(inQ.wr.geom, inQ.wr.addr,
                small_ram_block_pkg::geomWidth(inQ.wr.geom) - 1)) <
               int'(small_ram_block_pkg::physBit(rdGeom, inQ.rdAddr, 0))) ||
              (int'(small_ram_block_pkg::physBit(rdGeom, inQ.rdAddr,
                small_ram_block_pkg::geomWidth(rdGeom) - 1)) <
               int'(small_ram_block_pkg::physBit(inQ.wr.geom, inQ.wr.addr, 0))));
        stageWord = small_ram_block_pkg::readWord(memBits, rdGeom, inQ.rdAddr);
        if (collide && coreQ.ctrl[`CTRL_DONTCARE_BIT]) begin
            stageWord = `DONTCARE_WORD;
        end
        outD.latch = stageWord;
        outD.latchValid = inQ.rdPend;
        if (bypass && inQ.rdPend) begin
            outD.rdData = stageWord;
            outD.rdValid = 1'b1;
        end
        if (!bypass && outQ.latchValid) begin
            outD.rdData = outQ.latch;
            outD.rdValid = 1'b1;
        end

        // taps read one length apart behind the pointer being written, old contents first
        tapWord = '0;
        for (int b = 0; b < `MAX_WIDTH; b++) begin
            tj = b >> lw;
            if (tj < int'(coreQ.shiftTaps)) begin
                ta = int'(inQ.wr.addr) + shiftTotal - (tj + 1) * int'(coreQ.shiftLen);
                if (ta >= shiftTotal) begin
                    ta = ta - shiftTotal;
                end
                tapWord[b] = memBits[small_ram_block_pkg::physBit(wrGeom, ta[8:0],
                    b & ((1 << lw) - 1))];
            end
        end
        // last tap sits highest, feeds the next block when chained
        if (inQ.shiftGo) begin
            outD.rdData = tapWord;
            outD.rdValid = 1'b1;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            coreQ <= '0;
            coreQ.ctrl <= `CTRL_RESET;
            coreQ.shiftLen <= `SHIFT_LEN_RESET;
            coreQ.shiftTaps <= `SHIFT_TAPS_RESET;
        end else begin
            coreQ <= coreD;
        end
    end

    always_ff @(posedge sys_clk or posedge inClr) begin
        if (inClr) begin
            inQ <= '0;
        end else if (!rst_n) begin
            inQ <= '0;
        end else begin
            inQ <= inD;
        end
    end

    always_ff @(posedge sys_clk or posedge outClr) begin
        if (outClr) begin
            outQ <= '0;
        end else if (!rst_n) begin
            outQ <= '0;
        end else begin
            outQ <= outD;
        end
    end

    assign rdData = outQ.rdData;
    assign rdValid = outQ.rdValid;
    assign cfgRdData = coreQ.cfgRd;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    logic [9:0] parIdx;
    assign parIdx = small_ram_block_pkg::physBit(small_ram_block_pkg::GEOM_64X9, wrAddr, 8);

    a_outclr_immediate: assert property (@(posedge sys_clk) outClr |-> (rdData == 18'h00000) && !rdValid) else $error("output clear not seen at once");
    a_inclr_cancels: assert property (@(posedge sys_clk) disable iff (!rst_n) inClr |-> !inQ.wr.en && !inQ.rdPend) else $error("input clear left a request");
    a_inclr_no_early: assert property (@(posedge sys_clk) disable iff (!rst_n || outClr) (inClr && !bypass && outQ.latchValid) |=> rdValid) else $error("input clear reached output early");
    a_bypass_latency: assert property (@(posedge sys_clk) disable iff (!rst_n || inClr || outClr) (rdGo && bypass && !coreQ.ctrl[`CTRL_FLOW_BIT] && !cfgWrite) |-> ##2 rdValid) else $error("bypassed read not two cycles");
    a_reg_latency: assert property (@(posedge sys_clk) disable iff (!rst_n || inClr || outClr) (rdGo && !bypass && !cfgWrite) ##1 !cfgWrite |-> ##2 rdValid) else $error("registered read not three cycles");
    a_flow_latency: assert property (@(posedge sys_clk) disable iff (!rst_n || outClr) (rdGo && bypass && coreQ.ctrl[`CTRL_FLOW_BIT] && curMode == small_ram_block_pkg::MODE_SDP) |=> rdValid && (rdData == $past(small_ram_block_pkg::readWord(memBits, rdGeom, rdAddr)))) else $error("flow-through read wrong");
    a_rom_nowrite: assert property (@(posedge sys_clk) disable iff (!rst_n || inClr) ($past(curMode) == small_ram_block_pkg::MODE_ROM) && $past(!cfgWrite) |-> !inQ.wr.en) else $error("rom mode wrote");
    a_write_enable: assert property (@(posedge sys_clk) disable iff (!rst_n || inClr) !inClkEn |=> !inQ.wr.en) else $error("write without input enable");
    a_parity_lane: assert property (@(posedge sys_clk) disable iff (!rst_n || inClr) (wrGo && wrGeom == small_ram_block_pkg::GEOM_64X9 && curMode == small_ram_block_pkg::MODE_SDP) |-> ##2 memBits[$past(parIdx, 2)] == $past(wrData[8], 2)) else $error("parity bit not in ninth cell");
    a_parity_pairing: assert property (@(posedge sys_clk) disable iff (!rst_n) (small_ram_block_pkg::geomParity(wrGeom) && wrGeom != rdGeom) |-> cfgError && !wrGo && !rdGo) else $error("parity geometry mismatch accepted");
    a_shift_step: assert property (@(posedge sys_clk) disable iff (!rst_n || inClr) (curMode == small_ram_block_pkg::MODE_SHIFT && !cfgError && inClkEn && !cfgWrite) |=> inQ.shiftGo ##1 rdValid) else $error("shift did not step");
    a_dontcare_word: assert property (@(posedge sys_clk) disable iff (!rst_n || inClr || outClr) (collide && coreQ.ctrl[`CTRL_DONTCARE_BIT] && bypass) |=> rdData == `DONTCARE_WORD) else $error("collision did not give dont-care");
    a_fifo_bound: assert property (@(posedge sys_clk) disable iff (!rst_n) (curMode == small_ram_block_pkg::MODE_FIFO && !cfgError) |-> int'(coreQ.fifoCount) <= small_ram_block_pkg::geomDepth(wrGeom)) else $error("fifo count beyond depth");

endmodule

// *** rtl/small_ram_block_regs.svh ***
// offsets, field positions and reset values of the small ram block
`ifndef SMALL_RAM_BLOCK_REGS_SVH
`define SMALL_RAM_BLOCK_REGS_SVH

// ----------------------------------------
// configuration port map
// ----------------------------------------
`define CFG_CTRL_OFS 4'h0
`define CFG_SHIFT_OFS 4'h4
`define CFG_STATUS_OFS 4'h8

// ----------------------------------------
// control register fields
// ----------------------------------------
`define CTRL_MODE_LSB 0
`define CTRL_WRGEOM_LSB 4
`define CTRL_RDGEOM_LSB 8
`define CTRL_BYPASS_BIT 12
`define CTRL_DONTCARE_BIT 13
`define CTRL_FLOW_BIT 14
`define CTRL_RDCLK_BIT 15
`define CTRL_RESET 16'h0000

// ----------------------------------------
// shift register configuration fields
// ----------------------------------------
`define SHIFT_LEN_LSB 0
`define SHIFT_TAPS_LSB 16
`define SHIFT_LEN_RESET 9'h001
`define SHIFT_TAPS_RESET 5'h01

// ----------------------------------------
// status register fields
// ----------------------------------------
`define STAT_CFGERR_BIT 0
`define STAT_EMPTY_BIT 1
`define STAT_FULL_BIT 2
`define STAT_COUNT_LSB 8

// ----------------------------------------
// storage geometry
// ----------------------------------------
`define RAM_BITS 576
`define DATA_BITS 512
`define MAX_WIDTH 18
`define DONTCARE_WORD 18'h3FFFF

`endif

// *** rtl/small_ram_block_pkg.sv ***
// types and address mapping helpers of the small ram block
package small_ram_block_pkg;

    typedef enum logic [2:0] {MODE_SDP, MODE_SP, MODE_FIFO, MODE_ROM, MODE_SHIFT} mode_t;

    typedef enum logic [2:0] {
        GEOM_512X1, GEOM_256X2, GEOM_128X4, GEOM_64X8, GEOM_32X16, GEOM_64X9, GEOM_32X18
    } geom_t;

    typedef struct packed {
        logic en;
        logic [8:0] addr;
        logic [17:0] data;
        geom_t geom;
    } writeReq_t;

    function automatic int geomLog2(geom_t g);
        case (g)
            GEOM_512X1: return 0;
            GEOM_256X2: return 1;
            GEOM_128X4: return 2;
            GEOM_64X8: return 3;
            GEOM_64X9: return 3;
            default: return 4;
        endcase
    endfunction

    function automatic bit geomParity(geom_t g);
        return (g == GEOM_64X9) || (g == GEOM_32X18);
    endfunction

    function automatic int geomWidth(geom_t g);
        if (g == GEOM_64X9) return 9;
        if (g == GEOM_32X18) return 18;
        return 1 << geomLog2(g);
    endfunction

    function automatic int geomDepth(geom_t g);
        if (g == GEOM_64X9) return 64;
        if (g == GEOM_32X18) return 32;
        return 512 >> geomLog2(g);
    endfunction

    // each byte occupies nine cells, its ninth cell holds the parity bit
    function automatic logic [9:0] physBit(geom_t g, logic [8:0] a, int i);
        int k;
        int p;
        k = 0;
        p = 0;
        if (g == GEOM_64X9) begin
            p = int'(a[5:0]) * 9 + i;
        end else if (g == GEOM_32X18) begin
            p = int'(a[4:0]) * 18 + i;
        end else begin
            k = ((int'(a) << geomLog2(g)) + i) & 511;
            p = (k >> 3) * 9 + (k & 7);
        end
        return p[9:0];
    endfunction

    function automatic logic [17:0] readWord(logic [575:0] mem, geom_t g, logic [8:0] a);
        logic [17:0] r;
        r = '0;
        for (int i = 0; i < 18; i++) begin
            if (i < geomWidth(g)) begin
                r[i] = mem[physBit(g, a, i)];
            end
        end
        return r;
    endfunction

endpackage

// *** rtl/small_ram_array.sv ***
// storage cells of the small ram block with the mixed-width write port
`timescale 1ns/100ps
module small_ram_array #(
    parameter logic [575:0] INIT = '0
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire small_ram_block_pkg::writeReq_t wrReq,
    output logic [575:0] memBits
);
`include "small_ram_block_regs.svh"

    typedef struct packed {
        logic [575:0] cells;
    } arrayState_t;

    arrayState_t stateQ;
    arrayState_t stateD;

    // ----------------------------------------
    // write decode
    // ----------------------------------------
    always_comb begin
        stateD = stateQ;
        if (wrReq.en) begin
            for (int i = 0; i < `MAX_WIDTH; i++) begin
                if (i < small_ram_block_pkg::geomWidth(wrReq.geom)) begin
                    stateD.cells[small_ram_block_pkg::physBit(wrReq.geom, wrReq.addr, i)] =
                        wrReq.data[i];
                end
            end
        end
    end

    // preload from init data at reset
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            stateQ <= INIT;
        end else begin
            stateQ <= stateD;
        end
    end

    assign memBits = stateQ.cells;

endmodule

// *** verif/fabric_model.sv ***
// fabric-side driver of the small ram block, with the expected results
`timescale 1ns/100ps
module fabric_model (
    input wire logic sys_clk,
    output logic wrStrobe,
    output logic [8:0] wrAddr,
    output logic [17:0] wrData,
    output logic rdStrobe,
    output logic [8:0] rdAddr,
    output logic [3:0] cfgAddr,
    output logic [31:0] cfgWrData,
    output logic cfgWrite,
    output logic cfgRead
);
    logic [17:0] expQ[$];
    logic [31:0] cfgQ[$];
    // fabric owns strobes, addresses and data
    initial begin
        {wrStrobe, wrAddr, wrData, rdStrobe, rdAddr} = '0;
        {cfgAddr, cfgWrData, cfgWrite, cfgRead} = '0;
    end
    task automatic cfgWr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        cfgAddr <= a;
        cfgWrData <= d;
        cfgWrite <= 1'b1;
        @(posedge sys_clk);
        cfgWrite <= 1'b0;
        cfgWrData <= ~d;
    endtask
    task automatic cfgRd(input logic [3:0] a, input logic [31:0] e);
        cfgQ.push_back(e);
        @(posedge sys_clk);
        cfgAddr <= a;
        cfgRead <= 1'b1;
        @(posedge sys_clk);
        cfgRead <= 1'b0;
        cfgAddr <= ~a;
    endtask
    task automatic wr(input logic [8:0] a, input logic [17:0] d);
        @(posedge sys_clk);
        wrAddr <= a;
        wrData <= d;
        wrStrobe <= 1'b1;
        @(posedge sys_clk);
        wrStrobe <= 1'b0;
        wrData <= ~d;
    endtask
    // one shift step: input bit presented for the next edge
    task automatic step(input logic [17:0] d);
        wrData <= d;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [8:0] a, input logic [17:0] e);
        expQ.push_back(e);
        @(posedge sys_clk);
        rdAddr <= a;
        rdStrobe <= 1'b1;
        @(posedge sys_clk);
        rdStrobe <= 1'b0;
        rdAddr <= ~a;
    endtask
endmodule

// *** verif/small_ram_block_bench.sv ***
// self-checking bench of the small ram block
`timescale 1ns/100ps
module small_ram_block_bench;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic inClr = 1'b0;
    logic outClr = 1'b0;
    logic inClkEn = 1'b1;
    logic outClkEn = 1'b1;
    logic wrStrobe, rdStrobe, cfgWrite, cfgRead, rdValid;
    logic [8:0] wrAddr, rdAddr;
    logic [17:0] wrData, rdData;
    logic [3:0] cfgAddr;
    logic [31:0] cfgWrData, cfgRdData;
    logic cfgPend = 1'b0;
    logic [7:0] byteVal;
    logic [8:0] parVal;
    logic [8:0] shHist = 9'h000;
    int failures = 0;
    int comparisons = 0;
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    fabric_model fab (.sys_clk(sys_clk), .wrStrobe(wrStrobe), .wrAddr(wrAddr),
        .wrData(wrData), .rdStrobe(rdStrobe), .rdAddr(rdAddr), .cfgAddr(cfgAddr),
        .cfgWrData(cfgWrData), .cfgWrite(cfgWrite), .cfgRead(cfgRead));
    small_ram_block dut (.sys_clk(sys_clk), .rst_n(rst_n), .inClr(inClr), .outClr(outClr),
        .inClkEn(inClkEn), .outClkEn(outClkEn), .wrStrobe(wrStrobe), .wrAddr(wrAddr),
        .wrData(wrData), .rdStrobe(rdStrobe), .rdAddr(rdAddr), .rdData(rdData),
        .rdValid(rdValid), .cfgAddr(cfgAddr), .cfgWrData(cfgWrData), .cfgWrite(cfgWrite),
        .cfgRead(cfgRead), .cfgRdData(cfgRdData));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        if (failures == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic drain();
        for (int n = 0; n < 50 && fab.expQ.size() != 0; n++) @(posedge sys_clk);
        if (fab.expQ.size() != 0) begin
            failures++;
            test_done();
        end
    endtask
    // ----------------------------------------
    // result watcher
    // ----------------------------------------
    always @(posedge sys_clk) begin
        if (rdValid === 1'b1) begin
            check({14'h0000, rdData}, {14'h0000, fab.expQ.pop_front()});
        end
        if (cfgPend) begin
            check(cfgRdData, fab.cfgQ.pop_front());
        end
        cfgPend <= cfgRead;
    end
    initial begin
        repeat (5000) @(posedge sys_clk);
        failures++;
        test_done();
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        void'($urandom(2));
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        fab.cfgRd(4'h0, 32'h0000_0000);
        fab.cfgRd(4'h4, 32'h0001_0001);
        fab.cfgRd(4'hC, 32'h0000_0000);
        // byte written, read back bit by bit
        fab.cfgWr(4'h0, 32'h0000_0030);
        byteVal = 8'($urandom);
        fab.wr(9'h005, {10'h000, byteVal});
        for (int i = 0; i < 8; i++) fab.rd(9'(40 + i), {17'h00000, byteVal[i]});
        // nine-bit words keep the extra bit
        fab.cfgWr(4'h0, 32'h0000_0550);
        parVal = 9'($urandom);
        fab.wr(9'h006, {9'h000, parVal});
        fab.rd(9'h006, {9'h000, parVal});
        fab.cfgRd(4'h8, 32'h0000_0002);
        // parity write geometry against plain read geometry
        fab.cfgWr(4'h0, 32'h0000_0150);
        fab.cfgRd(4'h8, 32'h0000_0003);
        // rom ignores writes
        fab.cfgWr(4'h0, 32'h0000_0553);
        fab.cfgRd(4'h0, 32'h0000_0553);
        fab.wr(9'h006, {9'h000, ~parVal});
        fab.rd(9'h006, {9'h000, parVal});
        drain();
        @(posedge sys_clk);
        outClr <= 1'b1;
        #1 check({14'h0000, rdData}, 32'h0000_0000);
        @(posedge sys_clk);
        outClr <= 1'b0;
        drain();
        // shift register: 1 bit wide, two taps of length four
        inClkEn <= 1'b0;
        fab.cfgWr(4'h4, 32'h0002_0004);
        fab.cfgWr(4'h0, 32'h0000_0004);
        inClkEn <= 1'b1;
        for (int s = 0; s < 24; s++) begin
            shHist = {shHist[7:0], 1'($urandom)};
            fab.expQ.push_back({16'h0000, shHist[8], shHist[4]});
            fab.step({17'h00000, shHist[0]});
        end
        inClkEn <= 1'b0;
        drain();
        // fifo of bytes, first in first out
        fab.cfgWr(4'h0, 32'h0000_0332);
        inClkEn <= 1'b1;
        byteVal = 8'($urandom);
        fab.wr(9'h000, {10'h000, byteVal});
        fab.wr(9'h000, {10'h000, ~byteVal});
        fab.rd(9'h000, {10'h000, byteVal});
        fab.rd(9'h000, {10'h000, ~byteVal});
        fab.cfgRd(4'h8, 32'h0000_0002);
        drain();
        test_done();
    end
endmodule
